// ==== hw/sync_serial_tx.v ====
// Synchronous serial port, transmit path with register port
//
// Chosen here: the register offsets and strobed register access.
`timescale 1ns/100ps
`default_nettype none
`include "sync_serial_consts.vh"

module sync_serial_tx #(
  parameter DATA_W = 8,
  parameter ADDR_W = 8
) (
  input wire I_CORE_CLK,
  input wire I_RESET_N,
  input wire [ADDR_W-1:0] I_ADDR,
  input wire [DATA_W-1:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  output reg [DATA_W-1:0] O_RDATA,
  input wire I_PRESCALE_TAP_SELECT,
  input wire I_LOW_SPEED_MODE,
  input wire I_LOW_FREQ_CLOCK,
  input wire I_SERIAL_CLOCK_IN,
  output reg O_SERIAL_CLOCK_OUT,
  output wire O_SERIAL_CLOCK_OE,
  output reg O_SERIAL_OUT,
  output reg O_SERIAL_IRQ
);

  // ----------------------------------------
  // Declarations
  // ----------------------------------------
  reg transfer_run;
  reg [1:0] transfer_mode_select;
  reg bit_order_select;
  reg [2:0] clock_source;
  reg transfer_active_flag;
  reg partial_shift_flag;
  reg tx_buffer_empty_flag;
  reg tx_underrun_flag;
  reg [DATA_W-1:0] tx_holding_buffer;
  reg [DATA_W-1:0] shift_data;
  reg [2:0] bit_count;
  reg in_frame;
  reg loaded;
  reg irq_pending;
  reg ext_clk_q;
  wire ctl_wr;
  wire sts_wr;
  wire buf_wr;
  wire halt_req;
  wire external_clk;
  wire tx_mode;
  wire int_tick;
  wire int_fall;
  wire int_rise;
  wire ext_fall;
  wire ext_rise;
  wire fall_ev;
  wire rise_ev;
  wire may_start;
  wire [2:0] next_index;
  wire [2:0] first_index;
  wire [DATA_W-1:0] status_byte;
  wire [DATA_W-1:0] control_byte;

  assign ctl_wr = I_WR && (I_ADDR == `ADDR_CONTROL);
  assign sts_wr = I_WR && (I_ADDR == `ADDR_STATUS);
  assign buf_wr = I_WR && (I_ADDR == `ADDR_DATA_BUF);
  assign halt_req = ctl_wr && I_WDATA[`CTL_HALT];
  assign tx_mode = (transfer_mode_select == `MODE_TX_ONLY);
  assign external_clk = (clock_source == `SRC_EXTERNAL);
  assign O_SERIAL_CLOCK_OE = ~external_clk;

  // ----------------------------------------
  // Internal clock rate
  // ----------------------------------------
  // divider rates
  serial_rate_gen #(
    .CNT_W(12)
  ) u_rate (
    .i_clk(I_CORE_CLK),
    .i_reset_n(I_RESET_N),
    .i_enable(~external_clk & transfer_active_flag | may_start | in_frame),
    .i_code(clock_source),
    .i_tap_select(I_PRESCALE_TAP_SELECT),
    .i_low_speed(I_LOW_SPEED_MODE),
    .i_lf_clk(I_LOW_FREQ_CLOCK),
    .o_tick(int_tick)
  );

  // ----------------------------------------
  // Serial clock edges
  // ----------------------------------------
  // internal clock starts only with data written
  assign may_start = transfer_run && tx_mode && !tx_buffer_empty_flag && !external_clk;
  assign int_fall = int_tick && O_SERIAL_CLOCK_OUT && (in_frame || may_start);
  assign int_rise = int_tick && !O_SERIAL_CLOCK_OUT;
  assign ext_fall = external_clk && ext_clk_q && !I_SERIAL_CLOCK_IN;
  assign ext_rise = external_clk && !ext_clk_q && I_SERIAL_CLOCK_IN;
  assign fall_ev = external_clk ? ext_fall : int_fall;
  assign rise_ev = external_clk ? ext_rise : int_rise;

  assign first_index = bit_order_select ? `FIRST_BIT : `LAST_BIT;
  assign next_index = bit_order_select ? bit_count : (`LAST_BIT - bit_count);

  always @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      ext_clk_q <= 1'b1;
      O_SERIAL_CLOCK_OUT <= 1'b1;
    end
    else
    begin
      ext_clk_q <= I_SERIAL_CLOCK_IN;
      if (halt_req || external_clk)
      begin
        O_SERIAL_CLOCK_OUT <= 1'b1;
      end
      else if (int_fall)
      begin
        O_SERIAL_CLOCK_OUT <= 1'b0;
      end
      else if (int_rise)
      begin
        O_SERIAL_CLOCK_OUT <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Control register
  // ----------------------------------------
  always @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      transfer_run <= 1'b0;
      transfer_mode_select <= 2'h0;
      bit_order_select <= 1'b0;
      clock_source <= 3'h0;
    end
    else if (ctl_wr)
    begin
      transfer_mode_select <= I_WDATA[`CTL_MODE_HI:`CTL_MODE_LO];
      bit_order_select <= I_WDATA[`CTL_ORDER];
      clock_source <= I_WDATA[`CTL_SRC_HI:`CTL_SRC_LO];
      transfer_run <= I_WDATA[`CTL_RUN] & ~I_WDATA[`CTL_HALT];
    end
  end

  // ----------------------------------------
  // Holding buffer and shifter
  // ----------------------------------------
  always @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      tx_holding_buffer <= `BYTE_ZERO;
      tx_buffer_empty_flag <= 1'b1;
      tx_underrun_flag <= 1'b0;
      transfer_active_flag <= 1'b0;
      partial_shift_flag <= 1'b0;
      shift_data <= `BYTE_ONES;
      bit_count <= 3'h0;
      in_frame <= 1'b0;
      loaded <= 1'b0;
      irq_pending <= 1'b0;
      O_SERIAL_OUT <= 1'b1;
      O_SERIAL_IRQ <= 1'b0;
    end
    else if (halt_req)
    begin
      tx_holding_buffer <= `BYTE_ZERO;
      tx_buffer_empty_flag <= 1'b1;
      tx_underrun_flag <= 1'b0;
      transfer_active_flag <= 1'b0;
      partial_shift_flag <= 1'b0;
      shift_data <= `BYTE_ONES;
      bit_count <= 3'h0;
      in_frame <= 1'b0;
      loaded <= 1'b0;
      irq_pending <= 1'b0;
      O_SERIAL_OUT <= 1'b1;
      O_SERIAL_IRQ <= 1'b0;
    end
    else
    begin
      O_SERIAL_IRQ <= 1'b0;
      if (buf_wr && tx_buffer_empty_flag)
      begin
        tx_holding_buffer <= I_WDATA;
        tx_buffer_empty_flag <= 1'b0;
      end
      if (sts_wr && !I_WDATA[`STS_TX_UNDERRUN])
      begin
        tx_underrun_flag <= 1'b0;
      end
      if (!in_frame && !transfer_run)
      begin
        transfer_active_flag <= 1'b0;
        O_SERIAL_OUT <= 1'b1;
      end
      if (fall_ev)
      begin
        if (irq_pending)
        begin
          O_SERIAL_IRQ <= 1'b1;
          irq_pending <= 1'b0;
        end
        if (!in_frame)
        begin
          if (transfer_run && tx_mode)
          begin
            transfer_active_flag <= 1'b1;
            partial_shift_flag <= 1'b1;
            in_frame <= 1'b1;
            bit_count <= 3'h0;
            if (!tx_buffer_empty_flag)
            begin
              shift_data <= tx_holding_buffer;
              O_SERIAL_OUT <= tx_holding_buffer[first_index];
              loaded <= 1'b1;
            end
            else
            begin
              shift_data <= `BYTE_ONES;
              O_SERIAL_OUT <= 1'b1;
              loaded <= 1'b0;
              tx_underrun_flag <= 1'b1;
              irq_pending <= 1'b1;
            end
          end
        end
        else
        begin
          O_SERIAL_OUT <= shift_data[next_index];
          if (bit_count == `LAST_BIT)
          begin
            partial_shift_flag <= 1'b0;
          end
        end
      end
      if (rise_ev && in_frame)
      begin
        bit_count <= bit_count + 3'h1;
        if (bit_count == `FIRST_BIT && loaded)
        begin
          tx_buffer_empty_flag <= 1'b1;
          irq_pending <= 1'b1;
          loaded <= 1'b0;
        end
        if (bit_count == `LAST_BIT)
        begin
          in_frame <= 1'b0;
          if (!transfer_run)
          begin
            transfer_active_flag <= 1'b0;
            O_SERIAL_OUT <= 1'b1;
          end
        end
      end
      if (sts_wr && !I_WDATA[`STS_TX_UNDERRUN] && fall_ev && !in_frame
          && transfer_run && tx_mode && tx_buffer_empty_flag)
      begin
        // Set wins over a clear in the same cycle
        tx_underrun_flag <= 1'b1;
      end
    end
  end

  // ----------------------------------------
  // Read path
  // ----------------------------------------
  assign control_byte = {transfer_run, 1'b0, transfer_mode_select, bit_order_select,
                         clock_source};
  assign status_byte = {transfer_active_flag, partial_shift_flag, tx_buffer_empty_flag,
                        1'b0, tx_underrun_flag, 3'h0};

  always @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      O_RDATA <= `BYTE_ZERO;
    end
    else if (I_RD)
    begin
      case (I_ADDR)
        `ADDR_CONTROL: O_RDATA <= control_byte;
        `ADDR_STATUS: O_RDATA <= status_byte;
        default: O_RDATA <= `BYTE_ZERO;
      endcase
    end
    else
    begin
      O_RDATA <= `BYTE_ZERO;
    end
  end

endmodule // sync_serial_tx

`default_nettype wire

// ==== hw/sync_serial_consts.vh ====
// Constants for the synchronous serial transmit port
`ifndef SYNC_SERIAL_CONSTS_VH
`define SYNC_SERIAL_CONSTS_VH

// ----------------------------------------
// Register addresses
// ----------------------------------------
`define ADDR_DATA_BUF 8'h2B
`define ADDR_CONTROL 8'h31
`define ADDR_STATUS 8'h32

// ----------------------------------------
// Control register fields
// ----------------------------------------
`define CTL_RUN 7
`define CTL_HALT 6
`define CTL_MODE_HI 5
`define CTL_MODE_LO 4
`define CTL_ORDER 3
`define CTL_SRC_HI 2
`define CTL_SRC_LO 0
`define CTL_RESET 8'h00
`define MODE_TX_ONLY 2'h0
`define SRC_EXTERNAL 3'h7
`define SRC_SLOWEST 3'h0

// ----------------------------------------
// Status register fields
// ----------------------------------------
`define STS_ACTIVE 7
`define STS_PARTIAL 6
`define STS_TX_EMPTY 5
`define STS_RX_FULL 4
`define STS_TX_UNDERRUN 3
`define STS_RX_OVERRUN 2
`define BYTE_ZERO 8'h00
`define BYTE_ONES 8'hFF

// ----------------------------------------
// Serial clock half periods in core clocks, HALF_LF_EDGES in low-frequency clock rising edges
// ----------------------------------------
`define HALF_CODE0 12'h800
`define HALF_CODE1 12'h080
`define HALF_CODE2 12'h040
`define HALF_CODE3 12'h020
`define HALF_CODE4 12'h010
`define HALF_CODE5 12'h008
`define HALF_CODE6 12'h004
`define HALF_LF_EDGES 4'h8
`define LAST_BIT 3'h7
`define FIRST_BIT 3'h0

`endif

// ==== hw/serial_rate_gen.v ====
// Half-period tick generator for the internal serial clock
`timescale 1ns/100ps
`default_nettype none
`include "sync_serial_consts.vh"

module serial_rate_gen #(
  parameter CNT_W = 12
) (
  input wire i_clk,
  input wire i_reset_n,
  input wire i_enable,
  input wire [2:0] i_code,
  input wire i_tap_select,
  input wire i_low_speed,
  input wire i_lf_clk,
  output reg o_tick
);

  reg [CNT_W-1:0] count;
  reg [CNT_W-1:0] half;
  reg [3:0] lf_count;
  reg lf_q;
  reg use_lf;
  reg stopped;
  wire lf_rise;

  assign lf_rise = i_lf_clk & ~lf_q;

  // ----------------------------------------
  // Rate selection
  // ----------------------------------------
  always @*
  begin
    use_lf = 1'b0;
    stopped = 1'b0;
    half = `HALF_CODE0;
    case (i_code)
      3'h0: use_lf = i_tap_select | i_low_speed;
      3'h1: half = `HALF_CODE1;
      3'h2: half = `HALF_CODE2;
      3'h3: half = `HALF_CODE3;
      3'h4: half = `HALF_CODE4;
      3'h5: half = `HALF_CODE5;
      3'h6: half = `HALF_CODE6;
      default: stopped = 1'b1;
    endcase
    if (i_low_speed && (i_code != `SRC_SLOWEST))
    begin
      stopped = 1'b1;
    end
  end

  // ----------------------------------------
  // Counters
  // ----------------------------------------
  always @(posedge i_clk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      count <= {CNT_W{1'b0}};
      lf_count <= 4'h0;
      lf_q <= 1'b0;
      o_tick <= 1'b0;
    end
    else
    begin
      lf_q <= i_lf_clk;
      o_tick <= 1'b0;
      if (!i_enable || stopped)
      begin
        count <= {CNT_W{1'b0}};
        lf_count <= 4'h0;
      end
      else if (use_lf)
      begin
        if (lf_rise)
        begin
          if (lf_count == `HALF_LF_EDGES - 4'h1)
          begin
            lf_count <= 4'h0;
            o_tick <= 1'b1;
          end
          else
          begin
            lf_count <= lf_count + 4'h1;
          end
        end
      end
      else if (count == half - {{(CNT_W-1){1'b0}}, 1'b1})
      begin
        count <= {CNT_W{1'b0}};
        o_tick <= 1'b1;
      end
      else
      begin
        count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

endmodule // serial_rate_gen

`default_nettype wire

// ==== tb/sync_serial_tx_assertions.sv ====
// Checker for the serial transmit port
`timescale 1ns/100ps
`default_nettype none
`include "sync_serial_consts.vh"
module sync_serial_tx_assertions #(
  parameter DATA_W = 8,
  parameter ADDR_W = 8
) (
  input wire I_CORE_CLK,
  input wire I_RESET_N,
  input wire [ADDR_W-1:0] I_ADDR,
  input wire [DATA_W-1:0] I_WDATA,
  input wire I_WR,
  input wire I_RD,
  input wire [DATA_W-1:0] O_RDATA,
  input wire I_PRESCALE_TAP_SELECT,
  input wire I_LOW_SPEED_MODE,
  input wire I_LOW_FREQ_CLOCK,
  input wire I_SERIAL_CLOCK_IN,
  input wire O_SERIAL_CLOCK_OUT,
  input wire O_SERIAL_CLOCK_OE,
  input wire O_SERIAL_OUT,
  input wire O_SERIAL_IRQ
);
  reg [2:0] src;
  reg [1:0] mode;
  reg run;
  wire cw = I_WR && I_ADDR == `ADDR_CONTROL;
  wire dw = I_WR && I_ADDR == `ADDR_DATA_BUF;
  wire sc = O_SERIAL_CLOCK_OUT;
  wire oe = O_SERIAL_CLOCK_OE;
  wire pin = I_SERIAL_CLOCK_IN;
  // Shadow of the control fields
  always @(posedge I_CORE_CLK or negedge I_RESET_N)
  begin
    if (!I_RESET_N)
    begin
      src <= 3'h0;
      mode <= 2'h0;
      run <= 1'b0;
    end
    else if (cw)
    begin
      src <= I_WDATA[2:0];
      mode <= I_WDATA[5:4];
      run <= I_WDATA[7] && !I_WDATA[6];
    end
  end
  default clocking cb @(posedge I_CORE_CLK);
  endclocking
  default disable iff (!I_RESET_N);
  property p_oe;
    cw |=> oe == ($past(I_WDATA[2:0]) != 3'h7);
  endproperty
  property p_out;
    $changed(O_SERIAL_OUT) && oe |-> $fell(sc) || O_SERIAL_OUT;
  endproperty
  property p_ext;
    $changed(O_SERIAL_OUT) && !oe && !O_SERIAL_OUT
      |-> !pin && ($past(pin, 2) || $past(pin, 3) || $past(pin, 4));
  endproperty
  property p_irq;
    O_SERIAL_IRQ |=> !O_SERIAL_IRQ;
  endproperty
  property p_irqlo;
    O_SERIAL_IRQ && oe |-> !sc;
  endproperty
  property p_half;
    oe && src == 3'h6 && $fell(sc) |-> !sc [*4] ##1 sc;
  endproperty
  property p_mode;
    oe && $fell(sc) |-> mode == 2'h0;
  endproperty
  property p_start;
    dw && run && src == 3'h6 && mode == 2'h0 |-> ##[1:16] $fell(sc);
  endproperty
  property p_halt;
    cw && I_WDATA[6] && I_WDATA[2:0] != 3'h7 |=> sc && O_SERIAL_OUT;
  endproperty
  property p_rd;
    !$past(I_RD) |-> O_RDATA == 8'h00;
  endproperty
  a_oe: assert property (p_oe) else $error("clock enable wrong");
  a_out: assert property (p_out) else $error("data moved off fall");
  a_ext: assert property (p_ext) else $error("data moved off pin fall");
  a_irq: assert property (p_irq) else $error("request too long");
  a_irqlo: assert property (p_irqlo) else $error("request off fall");
  a_half: assert property (p_half) else $error("half period wrong");
  a_mode: assert property (p_mode) else $error("clock in other mode");
  a_start: assert property (p_start) else $error("start late");
  a_halt: assert property (p_halt) else $error("halt not idle");
  a_rd: assert property (p_rd) else $error("read data stray");
  c_irq: cover property (O_SERIAL_IRQ);
  c_ext: cover property (!oe && $fell(pin));
  c_halt: cover property (cw && I_WDATA[6]);
endmodule // sync_serial_tx_assertions
bind sync_serial_tx sync_serial_tx_assertions #(.DATA_W(DATA_W), .ADDR_W(ADDR_W)) u_chk (
  .I_CORE_CLK(I_CORE_CLK), .I_RESET_N(I_RESET_N), .I_ADDR(I_ADDR), .I_WDATA(I_WDATA),
  .I_WR(I_WR), .I_RD(I_RD), .O_RDATA(O_RDATA), .I_PRESCALE_TAP_SELECT(I_PRESCALE_TAP_SELECT),
  .I_LOW_SPEED_MODE(I_LOW_SPEED_MODE), .I_LOW_FREQ_CLOCK(I_LOW_FREQ_CLOCK),
  .I_SERIAL_CLOCK_IN(I_SERIAL_CLOCK_IN), .O_SERIAL_CLOCK_OUT(O_SERIAL_CLOCK_OUT),
  .O_SERIAL_CLOCK_OE(O_SERIAL_CLOCK_OE), .O_SERIAL_OUT(O_SERIAL_OUT),
  .O_SERIAL_IRQ(O_SERIAL_IRQ));
`default_nettype wire

// ==== tb/serial_peer.sv ====
// Model of the external serial device
`timescale 1ns/100ps
`default_nettype none
module serial_peer (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_sck,
  input wire logic i_data,
  output var logic o_drv,
  output var logic [15:0] o_sh,
  output var logic [7:0] o_bits
);
  initial
  begin
    o_drv = 1'b1;
    o_sh = 16'h0000;
    o_bits = 8'h00;
  end
  always @(posedge i_sck)
  begin
    if (i_rst_n)
    begin
      o_sh <= {o_sh[14:0], i_data};
      o_bits <= o_bits + 8'h01;
    end
  end
  task clocks(input int n);
    repeat (n)
    begin
      @(posedge i_clk) o_drv <= 1'b0;
      repeat (5) @(posedge i_clk);
      o_drv <= 1'b1;
      repeat (5) @(posedge i_clk);
    end
  endtask
endmodule // serial_peer
`default_nettype wire

// ==== tb/sync_serial_tx_tb.sv ====
// Testbench for the serial transmit port
`timescale 1ns/100ps
`default_nettype none
`include "sync_serial_consts.vh"
module sync_serial_tx_tb;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [7:0] wd = 8'h00;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic tap = 1'b0;
  logic lsm = 1'b0;
  logic lf = 1'b0;
  logic [7:0] v;
  logic [7:0] base;
  wire [7:0] rdat;
  wire sck_o, sck_oe, sout, irq, drv, pin;
  wire [15:0] sh;
  wire [7:0] bits;
  int errors = 0;
  int checked = 0;
  int cyc = 0;
  int irqs = 0;
  assign pin = sck_oe ? sck_o : drv;
  always #5 clk = ~clk;
  sync_serial_tx u_sync_serial_tx (.I_CORE_CLK(clk), .I_RESET_N(rst_n), .I_ADDR(addr),
    .I_WDATA(wd), .I_WR(wr), .I_RD(rd), .O_RDATA(rdat), .I_PRESCALE_TAP_SELECT(tap),
    .I_LOW_SPEED_MODE(lsm), .I_LOW_FREQ_CLOCK(lf), .I_SERIAL_CLOCK_IN(pin),
    .O_SERIAL_CLOCK_OUT(sck_o), .O_SERIAL_CLOCK_OE(sck_oe), .O_SERIAL_OUT(sout),
    .O_SERIAL_IRQ(irq));
  serial_peer u_serial_peer (.i_clk(clk), .i_rst_n(rst_n), .i_sck(pin), .i_data(sout),
    .o_drv(drv), .o_sh(sh), .o_bits(bits));
  task finish_test;
    $display("checks %0d errors %0d", checked, errors);
    if (errors == 0 && checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  // Ceiling well above the longest run
  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    lf <= cyc[1];
    if (irq === 1'b1)
      irqs <= irqs + 1;
    if (cyc == 60000)
    begin
      errors++;
      finish_test();
    end
  end
  task chk(input string n, input logic [15:0] s, input logic [15:0] e);
    checked++;
    if (s !== e)
    begin
      errors++;
      $display("[ERR] %s exp %h got %h", n, e, s);
    end
  endtask
  task wreg(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wd <= d;
    wr <= 1'b1;
    @(posedge clk);
    wr <= 1'b0;
  endtask
  task rc(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdat;
    chk(n, v & m, e);
  endtask
  task wpin(input logic l);
    int i;
    for (i = 0; i < 9000 && pin !== l; i++)
      @(negedge clk);
  endtask
  task t_reset;
    rc(`ADDR_CONTROL, 8'hFF, 8'h00, "ctl");
    rc(`ADDR_STATUS, 8'hFC, 8'h20, "sts");
    wreg(8'h40, 8'hFF);
    rc(8'h40, 8'hFF, 8'h00, "unmapped");
    rc(`ADDR_CONTROL, 8'hFF, 8'h00, "ctl");
    chk("idle", {sck_o, sout, sck_oe}, 3'h7);
  endtask
  task t_stream(input logic o, input logic [7:0] a, b, input logic [15:0] e);
    int n;
    int q;
    q = irqs;
    base = bits;
    wreg(`ADDR_CONTROL, {4'h8, o, 3'h6});
    repeat (40) @(posedge clk);
    rc(`ADDR_STATUS, 8'hFC, 8'h20, "no start");
    wreg(`ADDR_DATA_BUF, a);
    wpin(1'b0);
    n = cyc;
    rc(`ADDR_STATUS, 8'hC0, 8'hC0, "active");
    repeat (4) @(posedge clk);
    wreg(`ADDR_DATA_BUF, b);
    for (int i = 0; i < 400 && bits !== base + 8'h10; i++)
      @(negedge clk);
    chk("span", 16'(cyc - n), 16'd124);
    rc(`ADDR_STATUS, 8'hE0, 8'hA0, "stall");
    repeat (8) @(negedge clk);
    chk("stall clk", pin, 1'b1);
    wreg(`ADDR_CONTROL, {4'h0, o, 3'h6});
    repeat (4) @(posedge clk);
    rc(`ADDR_STATUS, 8'hFC, 8'h20, "stop");
    chk("out", sout, 1'b1);
    chk("word", sh, e);
    chk("irq", 16'(irqs - q), 16'd2);
  endtask
  task t_mode;
    wreg(`ADDR_DATA_BUF, 8'h5A);
    wreg(`ADDR_CONTROL, 8'h96);
    repeat (40) @(posedge clk);
    chk("mode clk", pin, 1'b1);
    rc(`ADDR_STATUS, 8'hFC, 8'h00, "mode");
    wreg(`ADDR_CONTROL, 8'h40);
  endtask
  task t_rate;
    int t;
    for (int k = 0; k < 3; k++)
    begin
      tap <= k == 1;
      lsm <= k == 2;
      wreg(`ADDR_DATA_BUF, 8'h55);
      wreg(`ADDR_CONTROL, 8'h80);
      wpin(1'b0);
      t = cyc;
      wpin(1'b1);
      chk("half", 16'(cyc - t), k > 0 ? 16'd32 : 16'd2048);
      wreg(`ADDR_CONTROL, 8'h40);
      @(negedge clk);
      chk("halt pins", {sck_o, sout}, 2'h3);
      rc(`ADDR_CONTROL, 8'hFF, 8'h00, "halt ctl");
      rc(`ADDR_STATUS, 8'hFC, 8'h20, "halt sts");
    end
    tap <= 1'b0;
    lsm <= 1'b0;
  endtask
  task t_ext;
    int q;
    wreg(`ADDR_CONTROL, 8'h07);
    @(negedge clk);
    chk("oe", sck_oe, 1'b0);
    wreg(`ADDR_DATA_BUF, 8'h69);
    wreg(`ADDR_DATA_BUF, 8'h96);
    rc(`ADDR_STATUS, 8'hFC, 8'h00, "full");
    q = irqs;
    wreg(`ADDR_CONTROL, 8'h87);
    u_serial_peer.clocks(4);
    rc(`ADDR_STATUS, 8'hE0, 8'hE0, "mid");
    u_serial_peer.clocks(4);
    rc(`ADDR_STATUS, 8'hC0, 8'h80, "eight");
    chk("ext byte", sh[7:0], 8'h69);
    u_serial_peer.clocks(8);
    rc(`ADDR_STATUS, 8'h08, 8'h08, "underrun");
    chk("held", sh[7:0], 8'hFF);
    chk("ext irq", 16'(irqs - q), 16'd2);
    wreg(`ADDR_STATUS, 8'h08);
    rc(`ADDR_STATUS, 8'h08, 8'h08, "one kept");
    wreg(`ADDR_CONTROL, 8'h07);
    rc(`ADDR_STATUS, 8'h08, 8'h08, "persist");
    wreg(`ADDR_STATUS, 8'h00);
    rc(`ADDR_STATUS, 8'h08, 8'h00, "cleared");
    wreg(`ADDR_CONTROL, 8'h87);
    u_serial_peer.clocks(3);
    wreg(`ADDR_CONTROL, 8'h47);
    rc(`ADDR_STATUS, 8'hFC, 8'h20, "ext halt");
    rc(`ADDR_CONTROL, 8'hFF, 8'h07, "ext ctl");
    chk("ext out", sout, 1'b1);
  endtask
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    t_reset();
    t_stream(1'b0, 8'h1E, 8'h46, 16'h1E46);
    t_stream(1'b1, 8'h1E, 8'h46, 16'h7862);
    t_mode();
    t_rate();
    t_ext();
    finish_test();
  end
endmodule // sync_serial_tx_tb
`default_nettype wire
